// ===== hdba_master.sv
// Overview of operation
// - read_not_write is high for dma reads and low for dma writes.
// - read_not_write, lower strobe, address strobe driven only during dma, else pulled high.
// - upper byte strobe asserted when the high lane carries data; pulled high otherwise.
// - slave acknowledges before T2 falling edge; wait states inserted until acknowledge seen.
// - low address latch enable pulses at the start of every dma cycle.
// - extended latch pulses before each block, on low-byte carry, and every cycle-steal transfer.
// - data_direction low for dma reads, high for dma writes.
// - data_buffer_en_n low during dma data transfers.
// - bus_owned_n held low while the device controls the bus.
// - all bus activity is timed from host_bus_clock.
// - grant input is synchronised to the core clock before use.
// - burst release during burst gives up the bus then re-requests; else ignored.
// - bus fault during dma terminates the operation abnormally.
// - high lane is host bits 15-8, low lane 7-0, pin 0 most significant.
// - each lane's parity pin carries odd parity of its byte; both are driven only while the low lane is driven.
// - grant sampled high on a falling edge; request driven two rising edges later.
// - take bus only when request, grant low and busy, fault, strobes, ack high.
// - first bus phase starts on the second falling edge after the good sample.
// - busy seen negated before taking the bus by driving bus_owned_n low.
// - request may return high once grant acknowledge is held.
// - busy input reads high when left unconnected.
// - arbitration inputs sampled on falling edges, outputs changed on rising edges.
// - in writes, data strobes assert one clock after address strobe falls.
module hdba_master (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic host_bus_clock_i,
	input wire hdba_pkg::hdba_cmd_s cmd_i,
	input wire hdba_pkg::hdba_pins_s pins_i,
	input wire logic [7:0] addr_data_high_lane_i,
	input wire logic [7:0] addr_data_low_lane_i,
	output logic busy_o,
	output logic done_o,
	output logic fault_o,
	output logic [15:0] rdata_o,
	output logic rdata_valid_o,
	output logic bus_request_n_o,
	output logic bus_owned_n_o,
	output logic read_not_write_o,
	output logic read_not_write_oe_o,
	output logic address_strobe_n_o,
	output logic address_strobe_n_oe_o,
	output logic upper_byte_strobe_n_o,
	output logic upper_byte_strobe_n_oe_o,
	output logic lower_byte_strobe_n_o,
	output logic lower_byte_strobe_n_oe_o,
	output logic low_addr_latch_en_o,
	output logic ext_addr_latch_en_o,
	output logic data_direction_o,
	output logic data_buffer_en_n_o,
	output logic [7:0] addr_data_high_lane_o,
	output logic [7:0] addr_data_low_lane_o,
	output logic addr_data_high_lane_oe_o,
	output logic addr_data_low_lane_oe_o,
	output logic parity_high_lane_o,
	output logic parity_low_lane_o,
	output logic parity_oe_o
);
	import hdba_pkg::*;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	// every outside pin passes two flops; only stage two is read
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	logic [15:0] lane_a;
	logic [15:0] lane_b;
	wire [NSYNC-1:0] raw_in = {host_bus_clock_i, pins_i};

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sync_a <= {NSYNC{1'b1}};
			sync_b <= {NSYNC{1'b1}};
			lane_a <= 16'h0000;
			lane_b <= 16'h0000;
		end else begin
			sync_a <= raw_in;
			sync_b <= sync_a;
			lane_a <= {addr_data_high_lane_i, addr_data_low_lane_i};
			lane_b <= lane_a;
		end
	end

	// named views of the synchronised pins
	wire bclk_s = sync_b[8];
	wire grant_n_s = sync_b[7];
	wire busy_n_s = sync_b[6]; // (pull-up keeps it high when open)
	wire release_n_s = sync_b[5];
	wire fault_n_s = sync_b[4];
	wire ack_n_s = sync_b[3];
	wire as_n_s = sync_b[2];
	wire uds_n_s = sync_b[1];
	wire lds_n_s = sync_b[0];

	// ------------------------------------------------------------
	// bus clock edge detection
	// ------------------------------------------------------------
	logic bclk_d;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			bclk_d <= 1'b1; // matches the synchroniser's reset level, so no false edge
		end else begin
			bclk_d <= bclk_s;
		end
	end
	wire bclk_rise = bclk_s & ~bclk_d;
	wire bclk_fall = ~bclk_s & bclk_d;

	// ------------------------------------------------------------
	// falling-edge samples of arbitration inputs
	// ------------------------------------------------------------
	// sample on bus clock falling edges only; request and ownership outputs change on rising edges
	logic grant_smp_n;
	logic own_ok;
	logic release_smp_n;
	logic fault_smp_n;
	logic ack_smp_n;
	wire next_own_ok = ~bus_request_n_o & ~grant_n_s & busy_n_s & fault_n_s
		& as_n_s & uds_n_s & lds_n_s & ack_n_s;

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			grant_smp_n <= 1'b1;
			own_ok <= 1'b0;
			release_smp_n <= 1'b1;
			fault_smp_n <= 1'b1;
			ack_smp_n <= 1'b1;
		end else if (bclk_fall) begin
			grant_smp_n <= grant_n_s;
			own_ok <= next_own_ok;
			release_smp_n <= release_n_s;
			fault_smp_n <= fault_n_s;
			ack_smp_n <= ack_n_s;
		end
	end

	// ------------------------------------------------------------
	// transfer bookkeeping
	// ------------------------------------------------------------
	hdba_state_e state;
	hdba_state_e next_state;
	logic [HDBA_ADDR_W-1:0] addr;
	logic [7:0] remain;
	logic is_write;
	logic is_burst;
	logic need_xal;
	logic rerequest;
	logic [2:0] edge_cnt;
	logic [15:0] wdata;
	logic use_upper;
	logic use_lower;
	logic all_done;
	logic aborted;

	wire last_xfer = (remain == 8'h00);
	// word addresses step by two, so the low byte carries out from fe or ff
	wire carry_low = ((addr[7:0] | 8'h01) == HDBA_LOW_CARRY);
	wire dma_active = (state != HDBA_IDLE) && (state != HDBA_CHKGNT);
	wire in_cycle = (state == HDBA_AS) || (state == HDBA_DS) || (state == HDBA_WAITACK);
	wire burst_cut = is_burst & ~release_smp_n & in_cycle; // (ignored outside burst)
	wire bus_err = ~fault_smp_n & dma_active;

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	// rising edges move request/own; falling edges move bus phases
	always_comb begin
		next_state = state;
		unique case (state)
			HDBA_IDLE: if (cmd_i.start) next_state = HDBA_CHKGNT;
			HDBA_CHKGNT: if (bclk_fall && grant_n_s) next_state = HDBA_REQ;
			HDBA_REQ: if (bclk_rise && edge_cnt == HDBA_REQ_DELAY - 3'h1) next_state = HDBA_WAITOWN;
			HDBA_WAITOWN: if (bclk_fall && own_ok && edge_cnt == HDBA_OWN_DELAY - 3'h1) next_state = HDBA_TX;
			HDBA_TX: if (bclk_fall) next_state = need_xal ? HDBA_XAL : HDBA_ALE;
			HDBA_XAL: if (bclk_fall) next_state = HDBA_ALE;
			HDBA_ALE: if (bclk_fall) next_state = HDBA_AS;
			HDBA_AS: if (bclk_fall) next_state = HDBA_DS;
			HDBA_DS: if (bclk_fall) next_state = HDBA_WAITACK;
			HDBA_WAITACK: if (bclk_fall && !ack_smp_n) next_state = HDBA_END;
			HDBA_END: if (bclk_fall) next_state = (last_xfer || !is_burst || rerequest) ? HDBA_FLOAT
				: (carry_low ? HDBA_XAL : HDBA_ALE);
			HDBA_FLOAT: if (bclk_rise) next_state = HDBA_RELEASE;
			HDBA_RELEASE: if (bclk_rise) next_state = all_done ? HDBA_IDLE : HDBA_CHKGNT;
			default: next_state = HDBA_IDLE;
		endcase
		if (bus_err && state != HDBA_FLOAT && state != HDBA_RELEASE) begin
			next_state = HDBA_FLOAT;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state <= HDBA_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// edge counter used while waiting for request and ownership
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			edge_cnt <= 3'h0;
		end else if (state == HDBA_REQ) begin
			if (bclk_rise) edge_cnt <= edge_cnt + 3'h1;
		end else if (state == HDBA_WAITOWN) begin
			if (bclk_fall) edge_cnt <= own_ok ? edge_cnt + 3'h1 : 3'h0;
		end else begin
			edge_cnt <= 3'h0;
		end
	end

	// address, count and mode bookkeeping
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			addr <= '0;
			remain <= 8'h00;
			is_write <= 1'b0;
			is_burst <= 1'b0;
			need_xal <= 1'b0;
			rerequest <= 1'b0;
			wdata <= 16'h0000;
			use_upper <= 1'b0;
			use_lower <= 1'b0;
		end else if (state == HDBA_IDLE && cmd_i.start) begin
			addr <= cmd_i.addr;
			remain <= cmd_i.count;
			is_write <= cmd_i.write;
			is_burst <= cmd_i.burst;
			need_xal <= 1'b1;
			rerequest <= 1'b0;
			wdata <= cmd_i.wdata;
			use_upper <= cmd_i.upper;
			use_lower <= cmd_i.lower;
		end else if (state == HDBA_END && bclk_fall) begin
			addr <= addr + 24'h000002;
			remain <= remain - 8'h01;
			need_xal <= ~is_burst | carry_low;
		end else if (burst_cut) begin
			rerequest <= 1'b1;
		end else if (state == HDBA_CHKGNT) begin
			rerequest <= 1'b0;
			need_xal <= 1'b1;
		end
	end

	// job end tracking; the count wraps after the last transfer, so it is not trusted then
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			all_done <= 1'b0;
			aborted <= 1'b0;
		end else if (state == HDBA_IDLE && cmd_i.start) begin
			all_done <= 1'b0;
			aborted <= 1'b0;
		end else if (bus_err) begin
			all_done <= 1'b1;
			aborted <= 1'b1;
		end else if (state == HDBA_END && bclk_fall && last_xfer) begin
			all_done <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// lane drive and parity
	// ------------------------------------------------------------
	// pin 0 is the msb, so each byte is bit-reversed onto its lane
	function automatic logic [7:0] hdba_rev(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7-i];
		end
		return r;
	endfunction

	wire [15:0] lane_word = (state == HDBA_XAL) ? {8'h00, addr[23:16]}
		: (state == HDBA_ALE || state == HDBA_TX) ? addr[15:0] : wdata;
	wire drive_addr = (state == HDBA_TX) || (state == HDBA_XAL) || (state == HDBA_ALE);
	wire drive_data = is_write && in_cycle;
	wire next_hi_oe = (drive_addr && state != HDBA_XAL) || (drive_data && use_upper);
	wire next_lo_oe = drive_addr || (drive_data && use_lower);
	wire next_strobe_oe = dma_active && state != HDBA_RELEASE && state != HDBA_FLOAT
		&& state != HDBA_CHKGNT && state != HDBA_REQ && state != HDBA_WAITOWN;
	wire next_ds_on = (state == HDBA_WAITACK) || (state == HDBA_DS);
	wire next_as_on = in_cycle;

	// registered pin drive; every output comes from a flop
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			addr_data_high_lane_o <= 8'h00;
			addr_data_low_lane_o <= 8'h00;
			addr_data_high_lane_oe_o <= 1'b0;
			addr_data_low_lane_oe_o <= 1'b0;
			parity_high_lane_o <= 1'b1;
			parity_low_lane_o <= 1'b1;
			parity_oe_o <= 1'b0;
		end else begin
			addr_data_high_lane_o <= hdba_rev(lane_word[15:8]);
			addr_data_low_lane_o <= hdba_rev(lane_word[7:0]);
			addr_data_high_lane_oe_o <= next_hi_oe;
			addr_data_low_lane_oe_o <= next_lo_oe;
			parity_high_lane_o <= ~^lane_word[15:8];
			parity_low_lane_o <= ~^lane_word[7:0];
			parity_oe_o <= next_lo_oe;
		end
	end

	// control strobes, latch enables and transceiver controls
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			read_not_write_o <= 1'b1;
			read_not_write_oe_o <= 1'b0;
			address_strobe_n_o <= 1'b1;
			address_strobe_n_oe_o <= 1'b0;
			upper_byte_strobe_n_o <= 1'b1;
			upper_byte_strobe_n_oe_o <= 1'b0;
			lower_byte_strobe_n_o <= 1'b1;
			lower_byte_strobe_n_oe_o <= 1'b0;
			low_addr_latch_en_o <= 1'b0;
			ext_addr_latch_en_o <= 1'b0;
			data_direction_o <= 1'b0;
			data_buffer_en_n_o <= 1'b1;
		end else begin
			read_not_write_o <= ~is_write | ~next_strobe_oe;
			read_not_write_oe_o <= next_strobe_oe;
			address_strobe_n_o <= ~next_as_on;
			address_strobe_n_oe_o <= next_strobe_oe;
			upper_byte_strobe_n_o <= ~(next_ds_on & use_upper);
			upper_byte_strobe_n_oe_o <= next_strobe_oe;
			lower_byte_strobe_n_o <= ~(next_ds_on & use_lower);
			lower_byte_strobe_n_oe_o <= next_strobe_oe;
			low_addr_latch_en_o <= (state == HDBA_ALE);
			ext_addr_latch_en_o <= (state == HDBA_XAL);
			data_direction_o <= is_write & next_strobe_oe;
			data_buffer_en_n_o <= ~(in_cycle && (is_write || state != HDBA_AS));
		end
	end

	// ------------------------------------------------------------
	// arbitration outputs and user status
	// ------------------------------------------------------------
	// request and ownership change only on bus clock rising edges
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			bus_request_n_o <= 1'b1;
			bus_owned_n_o <= 1'b1;
		end else if (bclk_rise) begin
			if (state == HDBA_REQ && edge_cnt == HDBA_REQ_DELAY - 3'h1) begin
				bus_request_n_o <= 1'b0;
			end else if (!bus_owned_n_o) begin
				bus_request_n_o <= 1'b1;
			end
			if (state == HDBA_WAITOWN && own_ok) begin
				bus_owned_n_o <= 1'b0;
			end else if (state == HDBA_RELEASE) begin
				bus_owned_n_o <= 1'b1;
			end
		end
	end

	// read data capture and completion reporting
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			rdata_o <= 16'h0000;
			rdata_valid_o <= 1'b0;
			done_o <= 1'b0;
			fault_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			rdata_valid_o <= 1'b0;
			done_o <= 1'b0;
			fault_o <= 1'b0;
			busy_o <= (next_state != HDBA_IDLE);
			if (state == HDBA_WAITACK && bclk_fall && !ack_smp_n && !is_write) begin
				rdata_o <= {hdba_rev(lane_b[15:8]), hdba_rev(lane_b[7:0])};
				rdata_valid_o <= 1'b1;
			end
			if (state == HDBA_RELEASE && next_state == HDBA_IDLE && !aborted) begin
				done_o <= 1'b1;
			end
			if (bus_err && state != HDBA_FLOAT && state != HDBA_RELEASE) begin
				fault_o <= 1'b1;
			end
		end
	end

endmodule

// ===== hdba_pkg.sv
package hdba_pkg;

	// ------------------------------------------------------------
	// timing and layout constants
	// ------------------------------------------------------------
	localparam int HDBA_ADDR_W = 24;
	localparam int HDBA_LANE_W = 8;
	localparam logic [7:0] HDBA_LOW_CARRY = 8'hff;
	localparam logic [2:0] HDBA_REQ_DELAY = 3'h2;  // rising edges from grant-high sample to request
	localparam logic [2:0] HDBA_OWN_DELAY = 3'h2;  // falling edges from sample to phase TX
	localparam logic [1:0] HDBA_WR_STROBE_LAG = 2'h1; // clocks from address strobe to data strobes

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		HDBA_IDLE = 4'h0,
		HDBA_CHKGNT = 4'h1,
		HDBA_REQ = 4'h2,
		HDBA_WAITOWN = 4'h3,
		HDBA_TX = 4'h4,
		HDBA_XAL = 4'h5,
		HDBA_ALE = 4'h6,
		HDBA_AS = 4'h7,
		HDBA_DS = 4'h8,
		HDBA_WAITACK = 4'h9,
		HDBA_END = 4'ha,
		HDBA_FLOAT = 4'hb,
		HDBA_RELEASE = 4'hc
	} hdba_state_e;

	// command from the adapter's dma engine
	typedef struct packed {
		logic start;
		logic write;
		logic burst;
		logic [HDBA_ADDR_W-1:0] addr;
		logic [7:0] count;
		logic upper;
		logic lower;
		logic [15:0] wdata;
	} hdba_cmd_s;

	// arbitration and control pins as the device sees them
	typedef struct packed {
		logic bus_grant_n;
		logic bus_busy_n;
		logic burst_release_n;
		logic bus_fault_n;
		logic transfer_ack_n;
		logic address_strobe_n;
		logic upper_byte_strobe_n;
		logic lower_byte_strobe_n;
	} hdba_pins_s;

endpackage

// ===== hdba_master_chk.sv
module hdba_master_chk (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire hdba_pkg::hdba_pins_s pins_i,
	input wire logic fault_o,
	input wire logic bus_owned_n_o,
	input wire logic read_not_write_o,
	input wire logic read_not_write_oe_o,
	input wire logic address_strobe_n_o,
	input wire logic address_strobe_n_oe_o,
	input wire logic lower_byte_strobe_n_o,
	input wire logic low_addr_latch_en_o,
	input wire logic data_direction_o,
	input wire logic [7:0] addr_data_high_lane_o,
	input wire logic addr_data_high_lane_oe_o,
	input wire logic addr_data_low_lane_oe_o,
	input wire logic parity_high_lane_o,
	input wire logic parity_oe_o
);
	import hdba_pkg::*;

	// ------------------------------------------------------------
	// pin checks, all on the core clock
	// ------------------------------------------------------------
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	// anything the block puts on the shared bus
	wire logic any_oe = read_not_write_oe_o | address_strobe_n_oe_o | addr_data_high_lane_oe_o | addr_data_low_lane_oe_o;

	a_dir_vs_rnw: assert property (
		address_strobe_n_oe_o && !address_strobe_n_o |-> data_direction_o != read_not_write_o)
		else $error("direction disagrees with read/write");
	a_drive_owned: assert property (
		any_oe |-> !bus_owned_n_o)
		else $error("bus driven without ownership");
	a_float_first: assert property (
		$rose(bus_owned_n_o) |-> !$past(any_oe))
		else $error("ownership dropped while still driving");
	a_odd_parity: assert property (
		parity_oe_o && addr_data_high_lane_oe_o |-> ^{addr_data_high_lane_o, parity_high_lane_o})
		else $error("high lane parity not odd");
	a_latch_early: assert property (
		low_addr_latch_en_o |-> !bus_owned_n_o && address_strobe_n_o)
		else $error("address latch outside address phase");
	a_take_bus: assert property (
		$fell(bus_owned_n_o) |-> pins_i.bus_busy_n && !pins_i.bus_grant_n && pins_i.bus_fault_n && pins_i.transfer_ack_n)
		else $error("bus taken without grant or while busy");
	a_write_lag: assert property (
		$fell(lower_byte_strobe_n_o) && !read_not_write_o |-> $past(address_strobe_n_o, 9) && !$past(address_strobe_n_o, 8))
		else $error("write strobe not one bus clock after address strobe");
	a_fault_abort: assert property (
		$fell(pins_i.bus_fault_n) && !bus_owned_n_o |-> ##[1:48] fault_o)
		else $error("bus fault not reported");
endmodule

bind hdba_master hdba_master_chk chk (.*);

// ===== hdba_host_model.sv
module hdba_host_model (
	input wire logic hclk_i,
	input wire logic slow_i,
	input wire logic fault_en_i,
	input wire logic release_en_i,
	input wire logic req_n_i,
	input wire logic own_n_i,
	input wire logic rnw_i,
	input wire logic upper_n_i,
	input wire logic lower_n_i,
	input wire logic ale_i,
	input wire logic xal_i,
	input wire logic [15:0] lanes_i,
	output logic grant_n_o = 1'h1,
	output logic busy_n_o = 1'h1,
	output logic ack_n_o = 1'h1,
	output logic fault_n_o = 1'h1,
	output logic release_n_o = 1'h1,
	output logic [15:0] lanes_o = 16'h0,
	output logic [15:0] addr_o,
	output logic [15:0] wdata_o,
	output logic [1:0] strb_o,
	output int xal_cnt_o = 0
);
	int waited = 0;
	wire logic strb = !(upper_n_i && lower_n_i);

	// host order <-> pin order: pin 0 of a lane is its msb, so the swap is its own inverse
	function automatic logic [15:0] swap(input logic [15:0] w);
		for (int i = 0; i < 8; i++) begin
			swap[8 + i] = w[15 - i];
			swap[i] = w[7 - i];
		end
	endfunction

	// processor grants a request only while nobody holds busy; glue follows ownership
	always @(posedge hclk_i) begin
		busy_n_o <= own_n_i;
		grant_n_o <= req_n_i | !busy_n_o;
	end

	// slave side; lanes it does not answer on flip every clock, there is no pull on them
	always @(posedge hclk_i) begin
		waited <= strb ? waited + 1 : 0;
		ack_n_o <= !(strb && !fault_en_i && waited >= (slow_i ? 3 : 0));
		fault_n_o <= !(fault_en_i && (strb || !fault_n_o) && !own_n_i);
		release_n_o <= !(release_en_i && strb);
		if (strb) strb_o <= {!upper_n_i, !lower_n_i};
		if (strb && !rnw_i) wdata_o <= swap(lanes_i);
		lanes_o <= (strb && rnw_i) ? swap(addr_o ^ 16'h5a3c) : ~lanes_o;
	end

	// external latch takes the address while its enable is open, away from the closing edge
	always @(posedge hclk_i) if (ale_i) addr_o <= swap(lanes_i);
	always @(posedge xal_i) xal_cnt_o <= xal_cnt_o + 1;
endmodule

// ===== hdba_master_tb.sv
module hdba_master_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import hdba_pkg::*;

	// ------------------------------------------------------------
	// nets, clocks and pin resolution
	// ------------------------------------------------------------
	typedef struct packed {
		logic write;
		logic burst;
		logic [23:0] addr;
		logic [7:0] count;
		logic [1:0] lanes;
		logic [15:0] wdata;
		logic [3:0] xal;
	} hdba_row_s;
	logic core_clk_i = 1'h0;
	logic rst_n_i = 1'h0;
	logic host_bus_clock_i = 1'h0;
	logic slow = 1'h0;
	logic fault_en = 1'h0;
	logic release_en = 1'h0;
	hdba_cmd_s cmd_i = '0;
	int failures = 0;
	int comparisons = 0;
	int own_falls = 0;
	int xal_cnt;
	wire logic done_o, fault_o, bus_request_n_o, bus_owned_n_o, low_addr_latch_en_o, ext_addr_latch_en_o;
	wire logic read_not_write_o, read_not_write_oe_o, address_strobe_n_o, address_strobe_n_oe_o;
	wire logic upper_byte_strobe_n_o, upper_byte_strobe_n_oe_o, lower_byte_strobe_n_o, lower_byte_strobe_n_oe_o;
	wire logic addr_data_high_lane_oe_o, addr_data_low_lane_oe_o, gnt_n, bsy_n, ack_n, flt_n, rls_n;
	wire logic [7:0] addr_data_high_lane_o, addr_data_low_lane_o;
	wire logic [15:0] rdata_o, host_lanes, seen_addr, seen_wdata;
	wire logic [1:0] seen_strb;
	// undriven control pins rise through their pull-ups
	wire logic rnw_pin = read_not_write_oe_o ? read_not_write_o : 1'h1;
	wire logic as_pin = address_strobe_n_oe_o ? address_strobe_n_o : 1'h1;
	wire logic us_pin = upper_byte_strobe_n_oe_o ? upper_byte_strobe_n_o : 1'h1;
	wire logic ls_pin = lower_byte_strobe_n_oe_o ? lower_byte_strobe_n_o : 1'h1;
	wire logic [7:0] addr_data_high_lane_i = addr_data_high_lane_oe_o ? addr_data_high_lane_o : host_lanes[15:8];
	wire logic [7:0] addr_data_low_lane_i = addr_data_low_lane_oe_o ? addr_data_low_lane_o : host_lanes[7:0];
	wire hdba_pins_s pins_i = '{gnt_n, bsy_n, rls_n, flt_n, ack_n, as_pin, us_pin, ls_pin};
	// write, burst, address, transfers-1, lanes, data, extended latch pulses
	localparam hdba_row_s rows [5] = '{
		'{1'h1, 1'h1, 24'h123400, 8'h03, 2'h3, 16'hc3a5, 4'h1},
		'{1'h0, 1'h1, 24'h450010, 8'h02, 2'h3, 16'h0000, 4'h1},
		'{1'h1, 1'h0, 24'h072200, 8'h01, 2'h2, 16'h9e71, 4'h2},
		'{1'h0, 1'h0, 24'h000100, 8'h00, 2'h3, 16'h0000, 4'h1},
		'{1'h0, 1'h1, 24'h3c0f00, 8'h01, 2'h1, 16'h0000, 4'h1}};

	always #10 core_clk_i = ~core_clk_i;
	// bus clock free-runs, offset so its edges never meet the core clock's
	initial begin
		#7;
		forever #80 host_bus_clock_i = ~host_bus_clock_i;
	end
	always @(negedge bus_owned_n_o) own_falls++;

	hdba_master uut (.*, .busy_o(), .rdata_valid_o(), .data_direction_o(), .data_buffer_en_n_o(),
		.parity_high_lane_o(), .parity_low_lane_o(), .parity_oe_o());
	hdba_host_model host (.hclk_i(host_bus_clock_i), .slow_i(slow), .fault_en_i(fault_en), .release_en_i(release_en),
		.req_n_i(bus_request_n_o), .own_n_i(bus_owned_n_o), .rnw_i(rnw_pin), .upper_n_i(us_pin), .lower_n_i(ls_pin),
		.ale_i(low_addr_latch_en_o), .xal_i(ext_addr_latch_en_o), .lanes_i({addr_data_high_lane_i, addr_data_low_lane_i}),
		.grant_n_o(gnt_n), .busy_n_o(bsy_n), .ack_n_o(ack_n), .fault_n_o(flt_n), .release_n_o(rls_n),
		.lanes_o(host_lanes), .addr_o(seen_addr), .wdata_o(seen_wdata), .strb_o(seen_strb), .xal_cnt_o(xal_cnt));

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one job; ends reports {fault, done}, zero if neither came in time
	task automatic run(input hdba_row_s r, output logic [1:0] ends);
		@(posedge core_clk_i);
		#2 cmd_i = '{1'h1, r.write, r.burst, r.addr, r.count, r.lanes[1], r.lanes[0], r.wdata};
		@(posedge core_clk_i);
		#2 cmd_i.start = 1'h0;
		ends = 2'h0;
		for (int n = 0; n < 6000 && ends == 2'h0; n++) begin
			@(posedge core_clk_i);
			#2 ends = {fault_o, done_o};
		end
	endtask

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		int xal0;
		logic [1:0] ends;
		logic [15:0] last;
		logic [15:0] m;
		repeat (12) @(posedge core_clk_i);
		#2 rst_n_i = 1'h1;
		foreach (rows[i]) begin
			slow = i[0];
			xal0 = xal_cnt;
			m = {{8{rows[i].lanes[1]}}, {8{rows[i].lanes[0]}}};
			last = rows[i].addr[15:0] + {7'h0, rows[i].count, 1'h0};
			run(rows[i], ends);
			chk("end", 16'h1, {14'h0, ends});
			chk("address", last, seen_addr);
			chk("strobes", {14'h0, rows[i].lanes}, {14'h0, seen_strb});
			if (rows[i].write) chk("wdata", rows[i].wdata & m, seen_wdata & m);
			else chk("rdata", (last ^ 16'h5a3c) & m, rdata_o & m);
			chk("ext latch", {12'h0, rows[i].xal}, 16'(xal_cnt - xal0));
			chk("request idle", 16'h1, {15'h0, bus_request_n_o});
			$display("row %0d done", i);
		end
		fault_en = 1'h1;
		run('{1'h1, 1'h1, 24'h200000, 8'h07, 2'h3, 16'h0ff0, 4'h1}, ends);
		fault_en = 1'h0;
		chk("fault end", 16'h2, {14'h0, ends});
		repeat (40) @(posedge core_clk_i);
		$display("fault test done");
		slow = 1'h1;
		release_en = 1'h1;
		own_falls = 0;
		run('{1'h0, 1'h1, 24'h500000, 8'h03, 2'h3, 16'h0000, 4'h1}, ends);
		release_en = 1'h0;
		chk("release end", 16'h1, {14'h0, ends});
		chk("ownerships", 16'h4, 16'(own_falls));
		$display("release test done");
		@(posedge core_clk_i);
		#2 cmd_i.start = 1'h1;
		@(posedge core_clk_i);
		#2 cmd_i.start = 1'h0;
		repeat (60) @(posedge core_clk_i);
		#2 rst_n_i = 1'h0;
		repeat (12) @(posedge core_clk_i);
		#2;
		chk("owned in reset", 16'h1, {15'h0, bus_owned_n_o});
		chk("strobe drive in reset", 16'h0, {15'h0, address_strobe_n_oe_o});
		rst_n_i = 1'h1;
		run(rows[0], ends);
		chk("end after reset", 16'h1, {14'h0, ends});
		$display("reset test done");
		end_sim;
	end

	// watchdog: the whole sequence needs well under a fifth of this span
	initial begin
		#1000000;
		failures++;
		end_sim;
	end
endmodule
